// >>> osst_cfg.svh
// Constants of the oscillator stop and settle timer
// What this block does and what software must do
// [RULE_01] Reset, STOP, x1_halt write clear settle status
// [RULE_02] Count starts when X1 oscillation is started
// [RULE_03] STOP release with X1 running restarts count
// [RULE_04] Status is thermometer coded, bits stay set
// [RULE_05] Select codes map to eight stage waits
// [RULE_06] Count halts at selected wait stage
// [RULE_07] X1 use held off until wait elapses
// [RULE_08] Select register resets to 07H
// [RULE_09] Select takes whole byte writes, bits 2:0
// [RULE_10] Status register read only, bit or byte
// [RULE_11] Software sets select before clearing x1_halt
// [RULE_12] Software writes pin mode before halt register
// [RULE_13] X1 halted only when high speed unused
// [RULE_14] XT1 halted only when main clock used
// [RULE_15] On-chip oscillator halted only when unused
// [RULE_16] Never halt the current CPU clock source
// [RULE_17] Software times XT1 settling itself
// [RULE_18] Run on-chip oscillator, stop XT1 per bits
// [RULE_19] Select wait longer than polled stage
// [RULE_20] Count excludes oscillator startup delay
// [RULE_21] x1_halt bit 7 runs or stops X1
// [RULE_22] Halt register resets to C0H
// [RULE_23] Report main clock source status
// [RULE_24] Count on X1 cycles, status in CPU domain
`ifndef OSST_CFG_SVH
`define OSST_CFG_SVH

// ----------------------------------------------------------------
// Register indices, byte address is four times the index
// ----------------------------------------------------------------
`define OSST_IDX_PIN_MODE   20'hFFFA0
`define OSST_IDX_HALT       20'hFFFA1
`define OSST_IDX_STATUS     20'hFFFA2
`define OSST_IDX_SELECT     20'hFFFA3
`define OSST_IDX_CLK_STATE  20'hFFFA6

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define OSST_RST_PIN_MODE   8'h00
`define OSST_RST_HALT       8'hC0
`define OSST_RST_STATUS     8'h00
`define OSST_RST_SELECT     3'h7

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define OSST_BIT_X1_HALT    7
`define OSST_BIT_XT1_HALT   6
`define OSST_BIT_HOCO_HALT  0
`define OSST_BIT_EXT_SEL    7
`define OSST_BIT_OSC_SEL    6
`define OSST_BIT_SUB_EXT    5
`define OSST_BIT_SUB_OSC    4
`define OSST_BIT_CLS        7
`define OSST_BIT_MCS        5
`define OSST_BIT_READY      0
`define OSST_HALT_MASK      8'hC1
`define OSST_PIN_MASK       8'hF7

// ----------------------------------------------------------------
// Stage waits in X1 cycles
// ----------------------------------------------------------------
`define OSST_WAIT_0         19'h00100
`define OSST_WAIT_1         19'h00200
`define OSST_WAIT_2         19'h00400
`define OSST_WAIT_3         19'h00800
`define OSST_WAIT_4         19'h02000
`define OSST_WAIT_5         19'h08000
`define OSST_WAIT_6         19'h20000
`define OSST_WAIT_7         19'h40000

// ----------------------------------------------------------------
// Bus responses
// ----------------------------------------------------------------
`define OSST_RESP_OKAY      2'h0
`define OSST_RESP_SLVERR    2'h2

`endif

// >>> osst_pkg.sv
// Types of the oscillator stop and settle timer
package osst_pkg;

  typedef struct packed {
    logic [18:0] count;
    logic [7:0]  status;
    logic        run;
  } osst_cnt_st_t;

  typedef struct packed {
    logic        aw_full;
    logic [31:0] aw_addr;
    logic        w_full;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [7:0]  pin_mode;
    logic        pin_locked;
    logic [7:0]  halt;
    logic [2:0]  sel;
    logic        x1_run_d;
  } osst_top_st_t;

endpackage : osst_pkg

// >>> osst_settle_if.sv
// Link between register side and settle counter
`timescale 1ns/1ns
interface osst_settle_if;
  logic       clear;
  logic       start;
  logic       tick;
  logic [2:0] sel;
  logic [7:0] status;
  logic       done;

  modport ctl (output clear, output start, output tick, output sel,
               input status, input done);
  modport cnt (input clear, input start, input tick, input sel,
               output status, output done);
endinterface : osst_settle_if

// >>> osst_settle_counter.sv
// Settle counter with thermometer stage status
`timescale 1ns/1ns
`include "osst_cfg.svh"
module osst_settle_counter
  import osst_pkg::*;
(
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Control and status
  osst_settle_if.cnt sif
);

  osst_cnt_st_t st_reg;
  osst_cnt_st_t st_next;

  function automatic logic [18:0] osst_wait(input logic [2:0] code);
    unique case (code)
      3'h0: osst_wait = `OSST_WAIT_0;
      3'h1: osst_wait = `OSST_WAIT_1;
      3'h2: osst_wait = `OSST_WAIT_2;
      3'h3: osst_wait = `OSST_WAIT_3;
      3'h4: osst_wait = `OSST_WAIT_4;
      3'h5: osst_wait = `OSST_WAIT_5;
      3'h6: osst_wait = `OSST_WAIT_6;
      3'h7: osst_wait = `OSST_WAIT_7;
    endcase
  endfunction : osst_wait

  always_comb begin
    st_next = st_reg;
    if (sif.clear) begin
      st_next.run    = 1'b0;                                // [RULE_01]
      st_next.count  = 19'h00000;
      st_next.status = `OSST_RST_STATUS;
    end else if (sif.start) begin
      st_next.run    = 1'b1;                                // [RULE_02] [RULE_03]
      st_next.count  = 19'h00000;
      st_next.status = `OSST_RST_STATUS;
    end else if (st_reg.run) begin
      // Ticks come only from a running oscillator          [RULE_20] [RULE_24]
      if (sif.tick && (st_reg.count < osst_wait(sif.sel))) begin
        st_next.count = st_reg.count + 19'h00001;           // [RULE_06]
      end
      for (int k = 0; k < 8; k++) begin
        if (st_reg.count >= osst_wait(3'(k))) begin
          st_next.status[7 - k] = 1'b1;                     // [RULE_04] [RULE_05]
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;                                         // [RULE_01]
    end else begin
      st_reg <= st_next;
    end
  end

  assign sif.status = st_reg.status;
  assign sif.done   = st_reg.run && (st_reg.count >= osst_wait(sif.sel)); // [RULE_07]

endmodule : osst_settle_counter

// >>> osst_clock_gate.sv
// Oscillator enables from halt and pin mode bits
`timescale 1ns/1ns
`include "osst_cfg.svh"
module osst_clock_gate
  import osst_pkg::*;
(
  // Control bits
  input  wire logic [7:0] halt,
  input  wire logic [7:0] pin_mode,
  input  wire logic       settle_done,
  // Oscillator controls
  output logic            x1_osc_en,
  output logic            ext_main_valid,
  output logic            x1_clk_use_ok,
  output logic            xt1_osc_en,
  output logic            ext_sub_valid,
  output logic            hoco_en
);

  logic main_on;
  logic sub_on;

  assign main_on        = !halt[`OSST_BIT_X1_HALT];               // [RULE_21]
  assign sub_on         = !halt[`OSST_BIT_XT1_HALT];              // [RULE_18]
  assign x1_osc_en      = main_on && !pin_mode[`OSST_BIT_EXT_SEL]
                          && pin_mode[`OSST_BIT_OSC_SEL];
  assign ext_main_valid = main_on && pin_mode[`OSST_BIT_EXT_SEL]
                          && pin_mode[`OSST_BIT_OSC_SEL];
  assign x1_clk_use_ok  = ext_main_valid || (x1_osc_en && settle_done); // [RULE_07]
  assign xt1_osc_en     = sub_on && !pin_mode[`OSST_BIT_SUB_EXT]
                          && pin_mode[`OSST_BIT_SUB_OSC];          // [RULE_18]
  assign ext_sub_valid  = sub_on && pin_mode[`OSST_BIT_SUB_EXT]
                          && pin_mode[`OSST_BIT_SUB_OSC];
  assign hoco_en        = !halt[`OSST_BIT_HOCO_HALT];             // [RULE_18]

endmodule : osst_clock_gate

// >>> osst_top.sv
// Oscillator stop controls and X1 settle timer with AXI4-Lite slave
`timescale 1ns/1ns
`include "osst_cfg.svh"
module osst_top
  import osst_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  // AXI4-Lite write data
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  // AXI4-Lite read data
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // CPU side events and clock status
  input  wire logic        stop_exec,
  input  wire logic        stop_release,
  input  wire logic        x1_tick,
  input  wire logic        cpu_clock_status_sub,
  input  wire logic        main_clock_status_ext,
  // Oscillator controls
  output logic             x1_osc_en,
  output logic             ext_main_valid,
  output logic             x1_clk_use_ok,
  output logic             xt1_osc_en,
  output logic             ext_sub_valid,
  output logic             hoco_en
);

  // ----------------------------------------------------------------
  // State and helpers
  // ----------------------------------------------------------------
  osst_top_st_t st_reg;
  osst_top_st_t st_next;
  osst_settle_if sif ();

  logic        x1_run;
  logic        wr_fire;
  logic        halt_x1_write;
  logic [7:0]  halt_wr_val;
  logic [7:0]  clk_state;

  function automatic logic osst_hit(input logic [31:0] addr,
                                    input logic [19:0] idx);
    osst_hit = (addr == {10'h000, idx, 2'h0});
  endfunction : osst_hit

  function automatic logic [7:0] osst_merge(input logic [7:0] old_val,
                                            input logic [7:0] new_val,
                                            input logic [7:0] mask);
    osst_merge = (old_val & ~mask) | (new_val & mask);
  endfunction : osst_merge

  // ----------------------------------------------------------------
  // Derived controls
  // ----------------------------------------------------------------
  assign x1_run = !st_reg.pin_mode[`OSST_BIT_EXT_SEL]
                  && st_reg.pin_mode[`OSST_BIT_OSC_SEL]
                  && !st_reg.halt[`OSST_BIT_X1_HALT];           // [RULE_02]

  assign wr_fire = st_reg.aw_full && st_reg.w_full && !st_reg.bvalid;

  assign halt_wr_val = osst_merge(st_reg.halt, st_reg.w_data[7:0],
                                  `OSST_HALT_MASK);

  assign halt_x1_write = wr_fire && st_reg.w_strb[0]
                         && osst_hit(st_reg.aw_addr, `OSST_IDX_HALT)
                         && halt_wr_val[`OSST_BIT_X1_HALT];       // [RULE_01]

  always_comb begin
    clk_state                     = 8'h00;
    clk_state[`OSST_BIT_CLS]      = cpu_clock_status_sub;
    clk_state[`OSST_BIT_MCS]      = main_clock_status_ext;      // [RULE_23]
    clk_state[`OSST_BIT_READY]    = x1_clk_use_ok;
  end

  // ----------------------------------------------------------------
  // Settle counter link
  // ----------------------------------------------------------------
  assign sif.clear = stop_exec || halt_x1_write
                     || st_reg.halt[`OSST_BIT_X1_HALT];           // [RULE_01]
  assign sif.start = (x1_run && !st_reg.x1_run_d)
                     || (stop_release && x1_run);                 // [RULE_02] [RULE_03]
  assign sif.tick  = x1_tick && x1_osc_en;                        // [RULE_20]
  assign sif.sel   = st_reg.sel;                                  // [RULE_05]

  osst_settle_counter u_counter (
    .aclk    (aclk),
    .aresetn (aresetn),
    .sif     (sif.cnt)
  );

  osst_clock_gate u_gate (
    .halt           (st_reg.halt),
    .pin_mode       (st_reg.pin_mode),
    .settle_done    (sif.done),
    .x1_osc_en      (x1_osc_en),
    .ext_main_valid (ext_main_valid),
    .x1_clk_use_ok  (x1_clk_use_ok),
    .xt1_osc_en     (xt1_osc_en),
    .ext_sub_valid  (ext_sub_valid),
    .hoco_en        (hoco_en)
  );

  // ----------------------------------------------------------------
  // Bus handshakes
  // ----------------------------------------------------------------
  assign s_axi_awready = !st_reg.aw_full && !st_reg.bvalid;
  assign s_axi_wready  = !st_reg.w_full && !st_reg.bvalid;
  assign s_axi_bvalid  = st_reg.bvalid;
  assign s_axi_bresp   = st_reg.bresp;
  assign s_axi_arready = !st_reg.rvalid;
  assign s_axi_rvalid  = st_reg.rvalid;
  assign s_axi_rdata   = st_reg.rdata;
  assign s_axi_rresp   = st_reg.rresp;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next          = st_reg;
    st_next.x1_run_d = x1_run;

    // Write address and data capture in either order
    if (s_axi_awvalid && s_axi_awready) begin
      st_next.aw_full = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_next.w_full = 1'b1;
      st_next.w_data = s_axi_wdata;
      st_next.w_strb = s_axi_wstrb;
    end

    // Write execution
    if (wr_fire) begin
      st_next.aw_full = 1'b0;
      st_next.w_full  = 1'b0;
      st_next.bvalid  = 1'b1;
      st_next.bresp   = `OSST_RESP_OKAY;
      if (osst_hit(st_reg.aw_addr, `OSST_IDX_PIN_MODE)) begin
        // Pin mode takes one write after reset
        if (st_reg.w_strb[0] && !st_reg.pin_locked) begin
          st_next.pin_mode   = st_reg.w_data[7:0] & `OSST_PIN_MASK;
          st_next.pin_locked = 1'b1;
        end
      end else if (osst_hit(st_reg.aw_addr, `OSST_IDX_HALT)) begin
        if (st_reg.w_strb[0]) begin
          st_next.halt = halt_wr_val;                            // [RULE_21]
        end
      end else if (osst_hit(st_reg.aw_addr, `OSST_IDX_SELECT)) begin
        if (st_reg.w_strb[0]) begin
          st_next.sel = st_reg.w_data[2:0];                      // [RULE_09]
        end else begin
          st_next.bresp = `OSST_RESP_SLVERR;                     // [RULE_09]
        end
      end else begin
        // Status and clock state are read only, rest unmapped
        st_next.bresp = `OSST_RESP_SLVERR;                       // [RULE_10]
      end
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end

    // Read path
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !st_reg.rvalid) begin
      st_next.rvalid = 1'b1;
      st_next.rresp  = `OSST_RESP_OKAY;
      st_next.rdata  = 32'h0000_0000;
      if (osst_hit(s_axi_araddr, `OSST_IDX_PIN_MODE)) begin
        st_next.rdata[7:0] = st_reg.pin_mode;
      end else if (osst_hit(s_axi_araddr, `OSST_IDX_HALT)) begin
        st_next.rdata[7:0] = st_reg.halt;
      end else if (osst_hit(s_axi_araddr, `OSST_IDX_STATUS)) begin
        st_next.rdata[7:0] = sif.status;                         // [RULE_10] [RULE_24]
      end else if (osst_hit(s_axi_araddr, `OSST_IDX_SELECT)) begin
        st_next.rdata[7:0] = {5'h00, st_reg.sel};                // [RULE_09]
      end else if (osst_hit(s_axi_araddr, `OSST_IDX_CLK_STATE)) begin
        st_next.rdata[7:0] = clk_state;                          // [RULE_23]
      end else begin
        st_next.rresp = `OSST_RESP_SLVERR;
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg          <= '0;
      st_reg.pin_mode <= `OSST_RST_PIN_MODE;
      st_reg.halt     <= `OSST_RST_HALT;                         // [RULE_22]
      st_reg.sel      <= `OSST_RST_SELECT;                       // [RULE_08]
    end else begin
      st_reg <= st_next;
    end
  end

endmodule : osst_top

// >>> osst_assertions.sv
// Concurrent checks of the oscillator stop and settle timer
`timescale 1ns/1ns
module osst_checker (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Read channel
  input  wire logic s_axi_arvalid,
  input  wire logic s_axi_arready,
  input  wire logic s_axi_rvalid,
  // Events
  input  wire logic stop_exec,
  input  wire logic stop_release,
  // Oscillator controls
  input  wire logic x1_osc_en,
  input  wire logic ext_main_valid,
  input  wire logic x1_clk_use_ok,
  input  wire logic xt1_osc_en,
  input  wire logic ext_sub_valid,
  input  wire logic hoco_en
);
  logic [19:0] since_start;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ----------------------------------------------
  // Cycles since the last count start, STOP or STOP release
  // ----------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || $rose(x1_osc_en) || stop_release || stop_exec)
      since_start <= '0;
    else if (since_start != 20'hFFFFF)
      since_start <= since_start + 20'h1;
  end

  rst_osc_a: assert property ($rose(aresetn) |->
    hoco_en && !x1_osc_en && !xt1_osc_en)
    else $error("oscillator enables wrong after reset");
  use_src_a: assert property (x1_clk_use_ok |->
    x1_osc_en || ext_main_valid)
    else $error("X1 use allowed with X1 stopped");
  start_hold_a: assert property ($rose(x1_osc_en) |->
    (!x1_clk_use_ok) [*8])
    else $error("X1 use allowed right after start");
  wait_min_a: assert property ($rose(x1_clk_use_ok) &&
    !ext_main_valid |-> since_start >= 20'h0FF)
    else $error("X1 use allowed before shortest wait");
  stop_clr_a: assert property (stop_exec && !ext_main_valid |->
    ##2 !x1_clk_use_ok)
    else $error("X1 use kept after STOP");
  rel_restart_a: assert property (stop_release && x1_osc_en |->
    ##2 !x1_clk_use_ok)
    else $error("count not restarted on STOP release");
  main_excl_a: assert property (!(x1_osc_en && ext_main_valid))
    else $error("X1 oscillator and external main both on");
  sub_excl_a: assert property (!(xt1_osc_en && ext_sub_valid))
    else $error("XT1 oscillator and external sub both on");
  rd_ans_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid)
    else $error("read answer late");
endmodule : osst_checker

bind osst_top osst_checker i_chk (
  .aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .stop_exec, .stop_release, .x1_osc_en, .ext_main_valid,
  .x1_clk_use_ok, .xt1_osc_en, .ext_sub_valid, .hoco_en
);

// >>> tb_osst_top.sv
// Self-checking bench of the oscillator stop and settle timer
`timescale 1ns/1ns
`include "osst_cfg.svh"
module tb_osst_top;
  logic        aclk, aresetn, x1_tick, stop_exec, stop_release;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        cpu_clock_status_sub, main_clock_status_ext;
  logic        x1_osc_en, ext_main_valid, x1_clk_use_ok;
  logic        xt1_osc_en, ext_sub_valid, hoco_en;
  logic [31:0] d;
  int          err_total, tests_run, n;

  osst_top i_dut (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_awprot, .s_axi_wvalid, .s_axi_wready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
    .s_axi_arprot, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .s_axi_rresp, .stop_exec, .stop_release, .x1_tick,
    .cpu_clock_status_sub, .main_clock_status_ext, .x1_osc_en,
    .ext_main_valid, .x1_clk_use_ok, .xt1_osc_en, .ext_sub_valid,
    .hoco_en);

  initial aclk = 1'b0;
  always #10 aclk = ~aclk;

  // ----------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------
  function automatic int wait_of(input int s);
    return (s == 7) ? 262144 : (s < 4) ? (256 << s) : (1 << (2 * s + 5));
  endfunction : wait_of

  function automatic logic [7:0] therm(input int s);
    return 8'hFF << (7 - s);
  endfunction : therm

  task automatic finish_test();
    if (err_total == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [19:0] idx, input logic [7:0] dat,
                    input logic [3:0] st, output logic [1:0] rsp);
    bit done;
    done = 1'b0;
    rsp  = 2'h3;
    @(posedge aclk);
    s_axi_awaddr  <= {10'h000, idx, 2'b00};
    s_axi_wdata   <= {24'($urandom()), dat};
    s_axi_wstrb   <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (int i = 0; i < 50 && !done; i++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) begin
      err_total++;
      finish_test();
    end
  endtask : wr

  task automatic rd(input logic [19:0] idx, output logic [33:0] res);
    bit done;
    done = 1'b0;
    res  = '1;
    @(posedge aclk);
    s_axi_araddr  <= {10'h000, idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (int i = 0; i < 50 && !done; i++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        res = {s_axi_rresp, s_axi_rdata};
        s_axi_rready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) begin
      err_total++;
      finish_test();
    end
  endtask : rd

  task automatic wrk(input logic [19:0] idx, input logic [7:0] dat);
    wr(idx, dat, 4'hF, r);
    chk(r, `OSST_RESP_OKAY);
  endtask : wrk

  task automatic rdk(input logic [19:0] idx, input logic [7:0] exp);
    logic [33:0] res;
    rd(idx, res);
    chk(res, {`OSST_RESP_OKAY, 24'h000000, exp});
  endtask : rdk

  task automatic wait_use(input int s);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (x1_clk_use_ok !== 1'b1 && n < 9000);
    chk(34'(n >= wait_of(s) - 4 && n <= wait_of(s) + 4), 34'h1);
    if (n >= 9000) finish_test();
  endtask : wait_use

  // ----------------------------------------------
  // Main sequence
  // ----------------------------------------------
  initial begin
    logic [33:0] res;
    void'($urandom(71159));
    err_total = 0;
    tests_run = 0;
    {aresetn, stop_exec, stop_release, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {cpu_clock_status_sub, main_clock_status_ext} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = '0;
    {s_axi_awprot, s_axi_arprot} = '0;
    x1_tick = 1'b1;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rdk(`OSST_IDX_HALT, 8'hC0);
    rdk(`OSST_IDX_STATUS, 8'h00);
    rdk(`OSST_IDX_SELECT, 8'h07);
    chk({hoco_en, x1_osc_en, xt1_osc_en}, 34'h4);
    for (int i = 0; i < 8; i++) begin
      wrk(`OSST_IDX_SELECT, {5'($urandom()), 3'(i)});
      rdk(`OSST_IDX_SELECT, 8'(i));
    end
    wr(`OSST_IDX_SELECT, 8'h02, 4'hE, r);
    chk(r, `OSST_RESP_SLVERR);
    rdk(`OSST_IDX_SELECT, 8'h07);
    wr(`OSST_IDX_STATUS, 8'hFF, 4'hF, r);
    chk(r, `OSST_RESP_SLVERR);
    rdk(`OSST_IDX_STATUS, 8'h00);
    rd(20'hFFFA4, res);
    chk(res, {`OSST_RESP_SLVERR, 32'h0});
    wrk(`OSST_IDX_PIN_MODE, 8'h50);
    for (int s = 0; s < 5; s++) begin
      wrk(`OSST_IDX_SELECT, 8'(s));
      wrk(`OSST_IDX_HALT, 8'h00);
      chk({x1_osc_en, xt1_osc_en, hoco_en}, 34'h7);
      chk({ext_main_valid, ext_sub_valid}, 34'h0);
      wait_use(s);
      cpu_clock_status_sub  <= 1'($urandom());
      main_clock_status_ext <= 1'($urandom());
      rdk(`OSST_IDX_STATUS, therm(s));
      rdk(`OSST_IDX_CLK_STATE, {cpu_clock_status_sub, 1'b0,
        main_clock_status_ext, 5'h01});
      @(posedge aclk) stop_release <= 1'b1;
      @(posedge aclk) stop_release <= 1'b0;
      wait_use(s);
      rdk(`OSST_IDX_STATUS, therm(s));
      if (s % 2 == 1) begin
        @(posedge aclk) stop_exec <= 1'b1;
        @(posedge aclk) stop_exec <= 1'b0;
        rdk(`OSST_IDX_STATUS, 8'h00);
        chk(x1_clk_use_ok, 34'h0);
      end
      cpu_clock_status_sub <= 1'b1;
      wrk(`OSST_IDX_HALT, 8'h81);
      rdk(`OSST_IDX_STATUS, 8'h00);
      chk({x1_osc_en, x1_clk_use_ok, hoco_en, xt1_osc_en}, 34'h1);
    end
    @(posedge aclk) aresetn <= 1'b0;
    cpu_clock_status_sub <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rdk(`OSST_IDX_HALT, 8'hC0);
    rdk(`OSST_IDX_STATUS, 8'h00);
    rdk(`OSST_IDX_SELECT, 8'h07);
    wrk(`OSST_IDX_PIN_MODE, 8'hFF);
    wrk(`OSST_IDX_PIN_MODE, 8'h50);
    rdk(`OSST_IDX_PIN_MODE, 8'hF7);
    wrk(`OSST_IDX_HALT, 8'h00);
    chk({ext_main_valid, ext_sub_valid, x1_clk_use_ok}, 34'h7);
    chk(x1_osc_en, 34'h0);
    finish_test();
  end
endmodule : tb_osst_top
